// >>> rtl/ddc_core.sv
// Datapath configuration and input control for a dual-channel interpolating converter.
// What this block does
// - Full bypass skips interpolation and oscillator and forces the sample clock as source.
// - Counter mode replaces input samples with an internal ramp.
// - Two's complement bit selects input format; clear means offset binary.
// - Resync enable, with PLL off: sampled strobe rising edge restarts the interpolation-factor divider.
// - B bus bit order is normal when clear and reversed when set.
// - Interleaved: marker bit picks marker pin, else gate rise aligns samples.
// - Spectrum invert negates the sine term before mixing.
// - Interleaved mode takes A and B streams both from the A bus.
// - Inverse-sinc filter is inserted only when enabled.
// - Two-clock select, with PLL off, latches on data clock, updates on sample clock.
// - Oscillator mix when enabled, else fixed quarter-rate mix; oscillator up to 350 MHz.
// - Serial interface uses four pins when set, three pins when clear.
// - Single sideband inverts the data routed to channel B, except in quadrature mode, where B carries uninverted channel A data.
// - Mixer mode: dual unmixed, quadrature uses channel B only, sideband drives both.
// - PLL output divider 1, 2, 4 or 8 applies only with PLL enabled.
// - Interpolation factor is two, four, eight or sixteen.
// - VCO boost raises bias in fifteen percent steps to forty-five percent.
// - Each channel holds a coarse gain from zero to fifteen.
// - Each channel holds a signed fine gain from -128 to 127.
// - Each channel holds a signed offset -1024 to 1023 added to its output, except in quadrature mode, where B carries A's offset.
// - Each channel has its own sleep control.
// - Gate-aligned interleave: first sample after gate rise is I, then alternates.
// - Marker interleave: marker high means Q, low means I.
// - Gate low stops processing and holds both outputs at constant level.
// - Strobe high clears the oscillator phase accumulator.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "ddc_defs.svh"
module ddc_core
  import ddc_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter logic [7:0] VERSION_ID = 8'h01, // Arbitrary silicon version value.
  parameter int ACC_W = 32
)(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pll_enable_i,
  input wire logic [DATA_W-1:0] a_input_bus_i,
  input wire logic [DATA_W-1:0] b_input_bus_i,
  input wire logic transmit_gate_i,
  input wire logic quadrature_marker_pin_i,
  input wire logic phase_strobe_pin_i,
  output logic [DATA_W-1:0] converter_channel_a_o,
  output logic [DATA_W-1:0] converter_channel_b_o,
  output logic channel_a_sleep_o,
  output logic channel_b_sleep_o,
  output logic lock_or_divclk_out_o,
  output logic four_wire_select_o,
  output logic sample_clock_only_o,
  output logic data_latch_clock_sel_o,
  output logic inverse_sinc_en_o,
  output logic pll_dither_o,
  output logic [1:0] pll_vco_div_o,
  output logic [1:0] vco_boost_o,
  output logic [3:0] coarse_gain_a_o,
  output logic [3:0] coarse_gain_b_o,
  output logic [7:0] fine_gain_a_o,
  output logic [7:0] fine_gain_b_o
);

  // Software-side registers.
  logic [31:0] cfg_q;
  logic [31:0] mode_q;
  logic [11:0] gain_a_q;
  logic [11:0] gain_b_q;
  logic [10:0] offs_a_q;
  logic [10:0] offs_b_q;
  logic [ACC_W-1:0] nco_step_q;

  // Live copies, taken only at sample boundaries.
  logic [31:0] cfg_l_q;
  logic [31:0] mode_l_q;
  logic [10:0] offs_a_l_q;
  logic [10:0] offs_b_l_q;

  logic wr_stb;
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

  // Byte-lane merge so partial writes keep untouched lanes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register writes; the mode word holds mix, interpolation, PLL divider and boost.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cfg_q <= `DDC_CFG_RESET;
      mode_q <= `DDC_MODE_RESET;
      gain_a_q <= 12'h000;
      gain_b_q <= 12'h000;
      offs_a_q <= 11'h000;
      offs_b_q <= 11'h000;
      nco_step_q <= '0;
    end
    else if (wr_stb)
    begin
      case (wb_adr_i)
        `DDC_OFF_CFG: cfg_q <= merge(cfg_q, wb_dat_i, wb_sel_i);
        `DDC_OFF_MODE: mode_q <= merge(mode_q, wb_dat_i, wb_sel_i);
        `DDC_OFF_GAIN_A: gain_a_q <= 12'(merge({20'h0, gain_a_q}, wb_dat_i, wb_sel_i));
        `DDC_OFF_GAIN_B: gain_b_q <= 12'(merge({20'h0, gain_b_q}, wb_dat_i, wb_sel_i));
        `DDC_OFF_OFFS_A: offs_a_q <= 11'(merge({21'h0, offs_a_q}, wb_dat_i, wb_sel_i));
        `DDC_OFF_OFFS_B: offs_b_q <= 11'(merge({21'h0, offs_b_q}, wb_dat_i, wb_sel_i));
        `DDC_OFF_VERSION: nco_step_q <= ACC_W'(merge(32'(nco_step_q), wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  logic [DATA_W-1:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;
  logic gate_s1_q, gate_s2_q, gate_d_q, mark_s1_q, mark_s2_q, strb_s1_q, strb_s2_q, strb_d_q;
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      a_s1_q <= '0;
      a_s2_q <= '0;
      b_s1_q <= '0;
      b_s2_q <= '0;
      gate_s1_q <= 1'b0;
      gate_s2_q <= 1'b0;
      gate_d_q <= 1'b0;
      mark_s1_q <= 1'b0;
      mark_s2_q <= 1'b0;
      strb_s1_q <= 1'b0;
      strb_s2_q <= 1'b0;
      strb_d_q <= 1'b0;
    end
    else
    begin
      a_s1_q <= a_input_bus_i;
      a_s2_q <= a_s1_q;
      b_s1_q <= b_input_bus_i;
      b_s2_q <= b_s1_q;
      gate_s1_q <= transmit_gate_i;
      gate_s2_q <= gate_s1_q;
      gate_d_q <= gate_s2_q;
      mark_s1_q <= quadrature_marker_pin_i;
      mark_s2_q <= mark_s1_q;
      strb_s1_q <= phase_strobe_pin_i;
      strb_s2_q <= strb_s1_q;
      strb_d_q <= strb_s2_q;
    end
  end

  logic strb_rise, gate_rise;
  assign strb_rise = strb_s2_q & ~strb_d_q;
  assign gate_rise = gate_s2_q & ~gate_d_q;

  // Sample-rate divider by the interpolation factor; its terminal count marks a sample boundary.
  logic [3:0] div_q;
  logic [3:0] div_last;
  logic smp_en;
  always_comb
  begin
    case (ddc_interp_t'(mode_l_q[3:2]))
      DDC_INT_X2: div_last = 4'h1;
      DDC_INT_X4: div_last = 4'h3;
      DDC_INT_X8: div_last = 4'h7;
      default: div_last = 4'hF;
    endcase
  end
  assign smp_en = cfg_l_q[`DDC_CFG_BYPASS] ? 1'b1 : (div_q == div_last);

  // Divider; a sampled strobe edge restarts it when resync is on and the PLL is off.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      div_q <= 4'h0;
      lock_or_divclk_out_o <= 1'b0;
    end
    else
    begin
      if (cfg_l_q[`DDC_CFG_RESYNC] && !pll_enable_i && strb_rise)
      begin
        div_q <= 4'h0;
      end
      else if (div_q >= div_last)
      begin
        div_q <= 4'h0;
      end
      else
      begin
        div_q <= div_q + 4'h1;
      end
      // PLL on: locked indication; PLL off: divided sample clock, high in the first half.
      lock_or_divclk_out_o <= pll_enable_i ? 1'b1 : (div_q <= (div_last >> 1));
    end
  end

  // Configuration is copied only on a sample boundary so no sample sees a half-applied mode.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cfg_l_q <= `DDC_CFG_RESET;
      mode_l_q <= `DDC_MODE_RESET;
      offs_a_l_q <= 11'h000;
      offs_b_l_q <= 11'h000;
    end
    else if (smp_en)
    begin
      cfg_l_q <= cfg_q;
      mode_l_q <= mode_q;
      offs_a_l_q <= offs_a_q;
      offs_b_l_q <= offs_b_q;
    end
  end

  // Input capture with format conversion to signed internal values.
  logic [DATA_W-1:0] b_ord;
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_rev
      assign b_ord[gi] = cfg_l_q[`DDC_CFG_BREV] ? b_s2_q[DATA_W-1-gi] : b_s2_q[gi];
    end
  endgenerate

  logic [DATA_W-1:0] ramp_q;
  logic iq_q;
  logic [DATA_W-1:0] i_q, q_q;
  logic [DATA_W-1:0] fmt_a, fmt_b;
  // Offset binary flips the top bit to become two's complement.
  assign fmt_a = cfg_l_q[`DDC_CFG_TWOS] ? a_s2_q : {~a_s2_q[DATA_W-1], a_s2_q[DATA_W-2:0]};
  assign fmt_b = cfg_l_q[`DDC_CFG_TWOS] ? b_ord : {~b_ord[DATA_W-1], b_ord[DATA_W-2:0]};

  // Sample capture; gate low freezes the samples and ramp and clears the I/Q toggle, so the outputs stay constant.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ramp_q <= '0;
      iq_q <= 1'b0;
      i_q <= '0;
      q_q <= '0;
    end
    else if (gate_s2_q && smp_en)
    begin
      if (cfg_l_q[`DDC_CFG_COUNTER])
      begin
        ramp_q <= ramp_q + 1'b1;
        i_q <= ramp_q;
        q_q <= ramp_q;
      end
      else if (cfg_l_q[`DDC_CFG_INTLV])
      begin
        if (cfg_l_q[`DDC_CFG_MARKER])
        begin
          if (mark_s2_q)
          begin
            q_q <= fmt_a;
          end
          else
          begin
            i_q <= fmt_a;
          end
        end
        else
        begin
          // First sample after the gate rise is I, then alternate.
          if (gate_rise || !iq_q)
          begin
            i_q <= fmt_a;
            iq_q <= 1'b1;
          end
          else
          begin
            q_q <= fmt_a;
            iq_q <= 1'b0;
          end
        end
      end
      else
      begin
        i_q <= fmt_a;
        q_q <= fmt_b;
      end
    end
    else if (!gate_s2_q)
    begin
      iq_q <= 1'b0;
    end
  end

  // Oscillator phase accumulator; strobe level clears it.
  logic [ACC_W-1:0] acc_q;
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      acc_q <= '0;
    end
    else if (strb_s2_q)
    begin
      acc_q <= '0;
    end
    else if (gate_s2_q && smp_en && !cfg_l_q[`DDC_CFG_BYPASS])
    begin
      acc_q <= acc_q + nco_step_q;
    end
  end

  // Quadrant of the mix: oscillator top bits, or a fixed fs/4 sequence from the divider.
  logic [1:0] quad;
  logic use_nco;
  assign use_nco = cfg_l_q[`DDC_CFG_NCO];
  assign quad = use_nco ? acc_q[ACC_W-1 -: 2] : div_q[1:0];

  // Coarse rotation by quadrant: cos/sin are +-1 or 0; sine optionally negated.
  logic [DATA_W-1:0] mix_a, mix_b, neg_i, neg_q, sin_q_term;
  assign neg_i = DATA_W'(~i_q + 1'b1);
  assign neg_q = DATA_W'(~q_q + 1'b1);
  assign sin_q_term = cfg_l_q[`DDC_CFG_SPECINV] ? neg_q : q_q;
  always_comb
  begin
    mix_a = i_q;
    mix_b = q_q;
    if (!cfg_l_q[`DDC_CFG_BYPASS] && ddc_mix_t'(mode_l_q[1:0]) != DDC_MIX_DUAL)
    begin
      case (quad)
        2'd0: mix_a = i_q;
        2'd1: mix_a = DATA_W'(~sin_q_term + 1'b1);
        2'd2: mix_a = neg_i;
        default: mix_a = sin_q_term;
      endcase
      case (quad)
        2'd0: mix_b = sin_q_term;
        2'd1: mix_b = i_q;
        2'd2: mix_b = DATA_W'(~sin_q_term + 1'b1);
        default: mix_b = neg_i;
      endcase
    end
  end

  // Channel outputs: mode routing, sideband inversion, offset add and sleep.
  logic [DATA_W-1:0] out_a, out_b;
  always_comb
  begin
    out_a = mix_a + DATA_W'(signed'(offs_a_l_q));
    out_b = (cfg_l_q[`DDC_CFG_SSB] ? ~mix_b : mix_b) + DATA_W'(signed'(offs_b_l_q));
    if (ddc_mix_t'(mode_l_q[1:0]) == DDC_MIX_QMOD)
    begin
      out_b = out_a;
      out_a = '0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      converter_channel_a_o <= '0;
      converter_channel_b_o <= '0;
    end
    else if (gate_s2_q && smp_en)
    begin
      converter_channel_a_o <= cfg_l_q[`DDC_CFG_SLEEP_A] ? '0 : out_a;
      converter_channel_b_o <= cfg_l_q[`DDC_CFG_SLEEP_B] ? '0 : out_b;
    end
  end

  // Static controls to the analog side, registered.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      channel_a_sleep_o <= 1'b0;
      channel_b_sleep_o <= 1'b0;
      four_wire_select_o <= 1'b0;
      sample_clock_only_o <= 1'b0;
      data_latch_clock_sel_o <= 1'b0;
      inverse_sinc_en_o <= 1'b0;
      pll_dither_o <= 1'b0;
      pll_vco_div_o <= 2'b00;
      vco_boost_o <= 2'b00;
      coarse_gain_a_o <= 4'h0;
      coarse_gain_b_o <= 4'h0;
      fine_gain_a_o <= 8'h00;
      fine_gain_b_o <= 8'h00;
    end
    else
    begin
      channel_a_sleep_o <= cfg_l_q[`DDC_CFG_SLEEP_A];
      channel_b_sleep_o <= cfg_l_q[`DDC_CFG_SLEEP_B];
      four_wire_select_o <= cfg_q[`DDC_CFG_SIF4];
      sample_clock_only_o <= cfg_l_q[`DDC_CFG_BYPASS];
      data_latch_clock_sel_o <= cfg_l_q[`DDC_CFG_TWOCLK] & ~pll_enable_i;
      inverse_sinc_en_o <= cfg_l_q[`DDC_CFG_INVSINC] & ~cfg_l_q[`DDC_CFG_BYPASS];
      pll_dither_o <= cfg_l_q[`DDC_CFG_DITHER];
      pll_vco_div_o <= pll_enable_i ? mode_l_q[5:4] : 2'b00;
      vco_boost_o <= mode_l_q[7:6];
      coarse_gain_a_o <= gain_a_q[3:0];
      coarse_gain_b_o <= gain_b_q[3:0];
      fine_gain_a_o <= gain_a_q[11:4];
      fine_gain_b_o <= gain_b_q[11:4];
    end
  end

  // Bus answer: one wait state, ack for a single cycle, unmapped reads return zero.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        `DDC_OFF_CFG: wb_dat_o <= cfg_q;
        `DDC_OFF_MODE: wb_dat_o <= mode_q;
        `DDC_OFF_GAIN_A: wb_dat_o <= {20'h0, gain_a_q};
        `DDC_OFF_GAIN_B: wb_dat_o <= {20'h0, gain_b_q};
        `DDC_OFF_OFFS_A: wb_dat_o <= {21'h0, offs_a_q};
        `DDC_OFF_OFFS_B: wb_dat_o <= {21'h0, offs_b_q};
        `DDC_OFF_STATUS: wb_dat_o <= {24'h0, VERSION_ID};
        `DDC_OFF_VERSION: wb_dat_o <= 32'(nco_step_q);
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> rtl/ddc_defs.svh
// Register offsets, field positions, reset values and the oscillator frequency limit for the datapath configuration block.
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
`define DDC_OFF_CFG 8'h00
`define DDC_OFF_MODE 8'h04
`define DDC_OFF_GAIN_A 8'h08
`define DDC_OFF_GAIN_B 8'h0C
`define DDC_OFF_OFFS_A 8'h10
`define DDC_OFF_OFFS_B 8'h14
`define DDC_OFF_STATUS 8'h18
`define DDC_OFF_VERSION 8'h1C
`define DDC_CFG_BYPASS 0
`define DDC_CFG_COUNTER 1
`define DDC_CFG_TWOS 2
`define DDC_CFG_RESYNC 3
`define DDC_CFG_DITHER 4
`define DDC_CFG_BREV 5
`define DDC_CFG_MARKER 6
`define DDC_CFG_SPECINV 7
`define DDC_CFG_INTLV 8
`define DDC_CFG_INVSINC 9
`define DDC_CFG_TWOCLK 10
`define DDC_CFG_NCO 11
`define DDC_CFG_SIF4 12
`define DDC_CFG_SSB 13
`define DDC_CFG_SLEEP_A 14
`define DDC_CFG_SLEEP_B 15
`define DDC_CFG_RESET 32'h0000_0000
`define DDC_MODE_RESET 32'h0000_0000
`define DDC_NCO_MAX_MHZ 350
`endif

// >>> rtl/ddc_pkg.sv
// Types shared by the datapath configuration block.
package ddc_pkg;
  typedef enum logic [1:0] {DDC_MIX_DUAL, DDC_MIX_QMOD, DDC_MIX_SSB, DDC_MIX_RSVD} ddc_mix_t;
  typedef enum logic [1:0] {DDC_INT_X2, DDC_INT_X4, DDC_INT_X8, DDC_INT_X16} ddc_interp_t;
  typedef enum logic [1:0] {DDC_PLL_DIV1, DDC_PLL_DIV2, DDC_PLL_DIV4, DDC_PLL_DIV8} ddc_plldiv_t;
endpackage

// >>> testbench/ddc_monitor.sv
// Port checker for the datapath configuration block.
`timescale 1ns/1ns
`default_nettype none
module ddc_monitor (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic pll_enable_i,
  input wire logic lock_or_divclk_out_o,
  input wire logic four_wire_select_o,
  input wire logic sample_clock_only_o,
  input wire logic data_latch_clock_sel_o,
  input wire logic inverse_sinc_en_o,
  input wire logic channel_a_sleep_o,
  input wire logic channel_b_sleep_o
);
  logic [15:0] cfg_q;
  logic wr_cfg;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Shadow of the low 16 bits of the configuration word; every write is taken as a whole-word write.
  assign wr_cfg = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00;
  // The shadow loads one edge after the write takes effect, while ack is high.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      cfg_q <= 16'h0000;
    else if (wr_cfg)
      cfg_q <= wb_dat_i[15:0];
  end
  property p_ack_one;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("request not answered in one cycle");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_sif4;
    wr_cfg |-> ##[1:2] four_wire_select_o == cfg_q[12];
  endproperty
  a_sif4: assert property (p_sif4) else $error("pin count select wrong");
  property p_sleep;
    wr_cfg |-> ##[1:40] {channel_b_sleep_o, channel_a_sleep_o} == cfg_q[15:14];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  property p_bypass;
    wr_cfg |-> ##[1:40] sample_clock_only_o == cfg_q[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass clock select wrong");
  property p_isinc;
    wr_cfg |-> ##[1:40] inverse_sinc_en_o == (cfg_q[9] && !cfg_q[0]);
  endproperty
  a_isinc: assert property (p_isinc) else $error("filter enable wrong");
  property p_twoclk;
    wr_cfg |-> ##[1:40] data_latch_clock_sel_o == (cfg_q[10] && !pll_enable_i);
  endproperty
  a_twoclk: assert property (p_twoclk) else $error("latch clock select wrong");
  property p_lock;
    pll_enable_i [*3] |-> lock_or_divclk_out_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock low with loop on");
  // A restart may stretch one high phase, hence a little slack above sixteen.
  property p_divclk;
    !pll_enable_i && $rose(lock_or_divclk_out_o) |-> ##[1:20] (!lock_or_divclk_out_o || pll_enable_i);
  endproperty
  a_divclk: assert property (p_divclk) else $error("divided clock stuck high");
endmodule
`default_nettype wire

// >>> testbench/ddc_src.sv
// Parallel data source model that feeds the converter input pins.
`timescale 1ns/1ns
`default_nettype none
module ddc_src (
  input wire logic clock_i,
  input wire logic gate_i,
  input wire logic ilv_i,
  input wire logic slow_i,
  input wire logic [15:0] word_a_i,
  input wire logic [15:0] word_b_i,
  output logic [15:0] a_bus_o,
  output logic [15:0] b_bus_o,
  output logic gate_o,
  output logic marker_o
);
  logic tick_q;
  logic q_phase_q;
  // Known start values, so the idle toggling below is never unknown.
  initial
  begin
    {a_bus_o, b_bus_o, gate_o, marker_o, tick_q, q_phase_q} = '0;
  end
  // Outside a burst the buses toggle so that a stale word never looks valid.
  always @(posedge clock_i)
  begin
    tick_q <= ~tick_q;
    gate_o <= gate_i;
    if (!gate_i)
    begin
      a_bus_o <= ~a_bus_o;
      b_bus_o <= ~b_bus_o;
      marker_o <= 1'b0;
      q_phase_q <= 1'b0;
    end
    else if (!slow_i || tick_q)
    begin
      a_bus_o <= (ilv_i && q_phase_q) ? word_b_i : word_a_i;
      b_bus_o <= ilv_i ? ~b_bus_o : word_b_i;
      marker_o <= ilv_i && q_phase_q;
      q_phase_q <= ilv_i && !q_phase_q;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_dac_datapath_config.sv
// Self-checking bench for the datapath configuration block.
`timescale 1ns/1ns
`default_nettype none
module test_dac_datapath_config;
  logic clock_i = 1'b0, reset_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, fg_b;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic pll_enable_i = 1'b1, phase_strobe_pin_i = 1'b0, gate = 1'b0, ilv = 1'b0, slow = 1'b0;
  logic [15:0] word_a = 16'h0, word_b = 16'h0, a_bus, b_bus, ch_a, ch_b;
  logic tx_gate, marker, lock;
  logic [1:0] vdiv, boost;
  logic [3:0] cg_b;
  int fails = 0, compares = 0;
  // Free-running 100 MHz clock.
  always #5 clock_i = ~clock_i;
  ddc_core u_ddc_core (.clock_i(clock_i), .reset_i(reset_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pll_enable_i(pll_enable_i), .a_input_bus_i(a_bus), .b_input_bus_i(b_bus),
    .transmit_gate_i(tx_gate), .quadrature_marker_pin_i(marker), .phase_strobe_pin_i(phase_strobe_pin_i),
    .converter_channel_a_o(ch_a), .converter_channel_b_o(ch_b), .channel_a_sleep_o(), .channel_b_sleep_o(),
    .lock_or_divclk_out_o(lock), .four_wire_select_o(), .sample_clock_only_o(), .data_latch_clock_sel_o(),
    .inverse_sinc_en_o(), .pll_dither_o(), .pll_vco_div_o(vdiv), .vco_boost_o(boost), .coarse_gain_a_o(),
    .coarse_gain_b_o(cg_b), .fine_gain_a_o(), .fine_gain_b_o(fg_b));
  ddc_src u_ddc_src (.clock_i(clock_i), .gate_i(gate), .ilv_i(ilv), .slow_i(slow), .word_a_i(word_a),
    .word_b_i(word_b), .a_bus_o(a_bus), .b_bus_o(b_bus), .gate_o(tx_gate), .marker_o(marker));
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // One classic cycle; everything is held until ack is sampled high.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, dat, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 32'h0, d);
    check(nm, d, exp);
  endtask
  function automatic logic [15:0] pick(input int s);
    case (s)
      0: return ch_a;
      1: return ch_b;
      2: return {14'h0, vdiv};
      3: return {14'h0, boost};
      4: return {12'h0, cg_b};
      5: return {8'h00, fg_b};
      default: return {15'h0, lock};
    endcase
  endfunction
  // Settings land at a sample boundary, so outputs are polled under a bound.
  task automatic wait_out(input string nm, input int s, input logic [15:0] exp);
    for (int n = 0; n < 200 && pick(s) !== exp; n++)
      @(posedge clock_i);
    check(nm, {16'h0, pick(s)}, {16'h0, exp});
    // A setting that has not landed after 200 cycles ends the run here.
    if (pick(s) !== exp)
      give_verdict();
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rdchk("cfg reset", 8'h00, 32'h0);
    rdchk("mode reset", 8'h04, 32'h0);
    bus(1'b0, 8'h18, 32'h0, d);
    check("version nonzero", {31'h0, d != 32'h0}, 32'h1);
    rdchk("unmapped", 8'h40, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    wr(8'h00, 32'h0000_D604);
    rdchk("cfg", 8'h00, 32'h0000_D604);
    wr(8'h04, 32'h0000_00B6);
    wr(8'h0C, 32'h0000_080F);
    wait_out("vco div", 2, 16'h0003);
    wait_out("boost", 3, 16'h0002);
    wait_out("coarse b", 4, 16'h000F);
    wait_out("fine b", 5, 16'h0080);
    wait_out("lock", 6, 16'h0001);
  endtask
  task automatic t_div;
    int r, lat[2];
    logic p;
    pll_enable_i <= 1'b0;
    wr(8'h00, 32'h0);
    for (int f = 0; f < 4; f++)
    begin
      wr(8'h04, 32'(f << 2));
      idle(40);
      r = 0;
      for (int c = 0; c < 64; c++)
      begin
        p = lock;
        @(posedge clock_i);
        if (p === 1'b0 && lock === 1'b1)
          r++;
      end
      check("divider rises", r, 64 >> (f + 1));
    end
    wr(8'h00, 32'h0000_0008);
    // Two strobes at different divider phases must give the same latency to the next fall.
    // A restart in the high half only stretches it, so a rise would depend on phase.
    for (int k = 0; k < 2; k++)
    begin
      idle(21 + 5 * k);
      phase_strobe_pin_i <= 1'b1;
      @(posedge clock_i);
      phase_strobe_pin_i <= 1'b0;
      lat[k] = 0;
      do
      begin
        p = lock;
        @(posedge clock_i);
        lat[k]++;
      end
      while (!(p === 1'b1 && lock === 1'b0 && lat[k] > 3) && lat[k] < 60);
    end
    check("restart latency", lat[1], lat[0]);
    if (lat[0] >= 60 || lat[1] >= 60)
    begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic t_data;
    logic [31:0] v;
    wr(8'h00, 32'h0000_0025);
    wr(8'h04, 32'h0);
    gate <= 1'b1;
    slow <= 1'b1;
    word_a <= 16'h1234;
    word_b <= 16'h0001;
    wait_out("a twos", 0, 16'h1234);
    wait_out("b reversed", 1, 16'h8000);
    wr(8'h00, 32'h0000_0001);
    word_a <= 16'hA5A5;
    wait_out("a offset binary", 0, 16'h25A5);
    wr(8'h10, 32'h0000_0010);
    wait_out("a with offset", 0, 16'h25B5);
    gate <= 1'b0;
    idle(10);
    v = {ch_b, ch_a};
    idle(20);
    check("held while gated", {ch_b, ch_a}, v);
    gate <= 1'b1;
    wr(8'h00, 32'h0000_0003);
    idle(40);
    v = {16'h0, ch_a};
    idle(9);
    check("ramp moves", {31'h0, ch_a !== v[15:0]}, 32'h1);
    wr(8'h10, 32'h0);
  endtask
  task automatic t_ilv;
    slow <= 1'b0;
    wr(8'h00, 32'h0000_0145);
    ilv <= 1'b1;
    word_a <= 16'h1111;
    word_b <= 16'h2222;
    wait_out("marker i", 0, 16'h1111);
    wait_out("marker q", 1, 16'h2222);
    wr(8'h00, 32'h0000_0105);
    gate <= 1'b0;
    word_b <= 16'h3333;
    word_a <= 16'h4444;
    idle(10);
    gate <= 1'b1;
    wait_out("gate i", 0, 16'h4444);
    wait_out("gate q", 1, 16'h3333);
  endtask
  task automatic t_qmod;
    ilv <= 1'b0;
    wr(8'h00, 32'h0000_0005);
    wr(8'h04, 32'h0000_0001);
    wait_out("quad mode a off", 0, 16'h0000);
    wait_out("quad mode b carries", 1, 16'h4444);
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial
  begin
    idle(8);
    reset_i <= 1'b0;
    t_regs();
    $display("regs done");
    t_div();
    $display("divider done");
    t_data();
    $display("data done");
    t_ilv();
    $display("interleave done");
    t_qmod();
    $display("quad mode done");
    give_verdict();
  end
endmodule
bind ddc_core ddc_monitor u_ddc_monitor (.clock_i(clock_i), .reset_i(reset_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .pll_enable_i(pll_enable_i), .lock_or_divclk_out_o(lock_or_divclk_out_o),
  .four_wire_select_o(four_wire_select_o), .sample_clock_only_o(sample_clock_only_o),
  .data_latch_clock_sel_o(data_latch_clock_sel_o), .inverse_sinc_en_o(inverse_sinc_en_o),
  .channel_a_sleep_o(channel_a_sleep_o), .channel_b_sleep_o(channel_b_sleep_o));
`default_nettype wire
